// ---- logic/apcc_cmd.v ----
`include "apcc_map.vh"

// ==========================================================
// Transmit data FIFO with registered ready and honest full and empty.
module apcc_fifo #(
    parameter W = 11,
    parameter D = 8,
    parameter AW = 3
) (
    input wire sys_clk_in,
    input wire rst_b_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [W-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [W-1:0] out_data_out
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] cnt_ff;
    reg ready_ff;
    reg [AW:0] nxt_cnt;
    wire push;
    wire pop;

    assign push = in_valid_in & ready_ff;
    assign pop = out_valid_out & out_ready_in;
    assign out_valid_out = (cnt_ff != {(AW+1){1'b0}});
    assign out_data_out = mem[rd_ptr_ff];
    assign in_ready_out = ready_ff;

    // Occupancy after this cycle's push and pop.
    always @* begin
        nxt_cnt = cnt_ff;
        if (push & ~pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop & ~push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    // Pointers, count and a ready that drops the cycle the last slot fills.
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
            ready_ff <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            cnt_ff <= nxt_cnt;
            ready_ff <= (nxt_cnt != D[AW:0]);
        end
    end

    // Storage has no reset; only written slots are ever read.
    always @(posedge sys_clk_in) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data_in;
        end
    end
endmodule

module apcc_cmd (
    input wire sys_clk_in,
    input wire rst_b_in,
    input wire cmd_valid_in,
    input wire [7:0] cmd_subaddr_in,
    input wire [7:0] cmd_code_in,
    input wire [15:0] cmd_count_in,
    input wire single_port_jumper_in,
    input wire [7:0] dsr_in,
    input wire [7:0] cts_in,
    input wire [7:0] full_duplex_in,
    input wire [7:0] ring_enable_in,
    input wire [7:0] port_reinit_in,
    input wire wr_data_valid_in,
    input wire [2:0] wr_data_port_in,
    input wire [7:0] wr_data_in,
    output wire wr_data_ready_out,
    output reg tx_valid_out,
    output reg [2:0] tx_port_out,
    output reg [7:0] tx_char_out,
    input wire tx_ready_in,
    input wire rx_valid_in,
    input wire [2:0] rx_port_in,
    input wire [7:0] rx_char_in,
    output reg rx_store_valid_out,
    output reg [2:0] rx_store_port_out,
    output reg [7:0] rx_store_char_out,
    output reg stat_valid_out,
    output reg [2:0] stat_port_out,
    output reg stat_tx_out,
    output reg [7:0] stat_code_out,
    output reg rd_start_out,
    output reg [2:0] rd_port_out,
    output reg [1:0] rd_type_out,
    output reg rd_ctl_det_out,
    output reg rd_spec_det_out,
    output reg rd_purge_out,
    output reg rd_dtr_flow_out,
    output reg [7:0] wr_active_out,
    output reg [7:0] tx_paused_out,
    output reg [7:0] monitor_out
);
    // ==========================================================
    // Helpers.

    // Index of the lowest set bit of an eight bit vector.
    function [2:0] apcc_lowest;
        input [7:0] v;
        integer k;
        begin
            apcc_lowest = `APCC_PORT_ZERO;
            for (k = 7; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    apcc_lowest = k[2:0];
                end
            end
        end
    endfunction

    // DSR gate, bypassed for a full duplex port with ring enabled.
    function apcc_dsr_ok;
        input [2:0] p;
        input [7:0] dsr;
        input [7:0] fd;
        input [7:0] ring;
        begin
            apcc_dsr_ok = dsr[p] | (fd[p] & ring[p]);
        end
    endfunction

    // ==========================================================
    // Per port state.
    reg [7:0] act_ff;
    reg [7:0] mon_wr_ff;
    reg [7:0] cts_wr_ff;
    reg [7:0] mon_ff;
    reg [7:0] pause_ff;
    reg [7:0] pend_ff;
    reg [`APCC_CNT_W-1:0] cnt_ff [0:`APCC_PORTS-1];

    // ==========================================================
    // Command decode.
    wire rx_hit;
    wire tx_hit;
    wire [2:0] cport;
    wire port_on;
    wire hit;
    wire is_w;
    wire is_r;
    wire w_mon;
    wire [3:0] rnib;
    wire uc;
    wire acc_w;
    wire acc_r;
    reg [1:0] rtype;

    assign rx_hit = (cmd_subaddr_in & `APCC_SA_PORT_MASK) == `APCC_SA_RX_BASE;
    assign tx_hit = (cmd_subaddr_in & `APCC_SA_PORT_MASK) == `APCC_SA_TX_BASE;
    assign cport = cmd_subaddr_in[2:0];
    assign port_on = ~single_port_jumper_in | (cport == `APCC_PORT_ZERO);
    assign hit = cmd_valid_in & (rx_hit | tx_hit) & port_on;
    // Write codes are exact bytes.
    assign is_w = (cmd_code_in == `APCC_WR_PLAIN) | (cmd_code_in == `APCC_WR_MON) |
        (cmd_code_in == `APCC_WR_HW);
    assign w_mon = (cmd_code_in == `APCC_WR_MON);
    assign rnib = cmd_code_in[3:0];
    // Read codes: top bit clear except for the hardware flow read.
    assign is_r = (rnib == `APCC_RD_TYPE_HW) |
        (~cmd_code_in[`APCC_RD_SEL_BIT] & ((rnib == `APCC_RD_TYPE_READ) |
        (rnib == `APCC_RD_TYPE_ECHO) | (rnib == `APCC_RD_TYPE_FLOW)));

    // Read type from the low nibble.
    always @* begin
        case (rnib)
            `APCC_RD_TYPE_ECHO: rtype = `APCC_RT_ECHO;
            `APCC_RD_TYPE_FLOW: rtype = `APCC_RT_FLOW;
            `APCC_RD_TYPE_HW: rtype = `APCC_RT_HW;
            default: rtype = `APCC_RT_READ;
        endcase
    end

    // Unit check causes; a read on the receive side never checks write activity.
    assign uc = ~apcc_dsr_ok(cport, dsr_in, full_duplex_in, ring_enable_in) |
        (tx_hit & ~is_w) | (rx_hit & ~is_r) |
        (tx_hit & act_ff[cport]) |
        (tx_hit & (cmd_count_in == `APCC_CNT_ZERO)) |
        (tx_hit & w_mon & ~full_duplex_in[cport]);
    assign acc_w = hit & tx_hit & ~uc;
    assign acc_r = hit & rx_hit & ~uc;

    // ==========================================================
    // Transmit path.
    wire fifo_valid;
    wire [`APCC_FIFO_W-1:0] fifo_data;
    wire [2:0] hp;
    wire can_load;
    wire hold;
    wire send;
    wire pop;
    wire fin;

    assign hp = fifo_data[10:8];
    assign can_load = ~tx_valid_out | tx_ready_in;
    // Pause by DC3 and CTS stall only bite on flow controlled writes.
    assign hold = (mon_wr_ff[hp] & pause_ff[hp]) |
        (cts_wr_ff[hp] & ~cts_in[hp]);
    assign send = fifo_valid & act_ff[hp] & can_load & ~hold;
    // Data for a port with no write in progress is dropped so it cannot block others.
    assign pop = send | (fifo_valid & ~act_ff[hp]);
    assign fin = send & (cnt_ff[hp] == `APCC_CNT_ONE);

    apcc_fifo #(
        .W(`APCC_FIFO_W),
        .D(`APCC_FIFO_DEPTH),
        .AW(`APCC_FIFO_AW)
    ) u_fifo (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(wr_data_valid_in),
        .in_ready_out(wr_data_ready_out),
        .in_data_in({wr_data_port_in, wr_data_in}),
        .out_valid_out(fifo_valid),
        .out_ready_in(pop),
        .out_data_out(fifo_data)
    );

    // ==========================================================
    // Receive character screening.
    wire is_dc3;
    wire is_dc1;
    wire is_etx;
    wire consume;
    wire etx_end;

    assign is_dc3 = rx_char_in == `APCC_CH_DC3;
    assign is_dc1 = rx_char_in == `APCC_CH_DC1;
    assign is_etx = rx_char_in == `APCC_CH_ETX;
    // Flow characters are swallowed while the port watches; ETX only mid write.
    assign consume = rx_valid_in & mon_ff[rx_port_in] &
        (is_dc3 | is_dc1 | (is_etx & mon_wr_ff[rx_port_in]));
    assign etx_end = rx_valid_in & is_etx & mon_wr_ff[rx_port_in] &
        act_ff[rx_port_in];

    // ==========================================================
    // Completion events and status selection.
    reg [7:0] done_set;
    integer j;
    wire [2:0] dp;
    wire reject;
    wire [7:0] served;

    // One completion bit per port, from byte count exhaustion or ETX.
    always @* begin
        for (j = 0; j < `APCC_PORTS; j = j + 1) begin
            done_set[j] = (fin & (hp == j[2:0])) | (etx_end & (rx_port_in == j[2:0]));
        end
    end

    assign reject = hit & uc;
    assign dp = apcc_lowest(pend_ff);
    // A pending completion goes out only in a cycle with no reject to report.
    assign served = (~reject & (pend_ff != 8'h00)) ? (8'h01 << dp) : 8'h00;

    // ==========================================================
    // Per port state update; a write accept wins over completion, reinit wins over both.
    integer i;
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            act_ff <= 8'h00;
            mon_wr_ff <= 8'h00;
            cts_wr_ff <= 8'h00;
            mon_ff <= 8'h00;
            pause_ff <= 8'h00;
            pend_ff <= 8'h00;
            for (i = 0; i < `APCC_PORTS; i = i + 1) begin
                cnt_ff[i] <= `APCC_CNT_ZERO;
            end
        end else begin
            pend_ff <= (pend_ff & ~served) | done_set;
            for (i = 0; i < `APCC_PORTS; i = i + 1) begin
                if (send & (hp == i[2:0])) begin
                    cnt_ff[i] <= cnt_ff[i] - `APCC_CNT_ONE;
                end
                if (done_set[i]) begin
                    act_ff[i] <= 1'b0;
                    mon_wr_ff[i] <= 1'b0;
                    cts_wr_ff[i] <= 1'b0;
                end
                if (rx_valid_in & (rx_port_in == i[2:0]) & mon_ff[i]) begin
                    if (is_dc3) begin
                        pause_ff[i] <= 1'b1;
                    end else if (is_dc1) begin
                        pause_ff[i] <= 1'b0;
                    end
                end
                if (port_reinit_in[i]) begin
                    act_ff[i] <= 1'b0;
                    mon_wr_ff[i] <= 1'b0;
                    cts_wr_ff[i] <= 1'b0;
                    mon_ff[i] <= 1'b0;
                    pause_ff[i] <= 1'b0;
                end else if (acc_w & (cport == i[2:0])) begin
                    act_ff[i] <= 1'b1;
                    cnt_ff[i] <= cmd_count_in;
                    mon_wr_ff[i] <= w_mon;
                    cts_wr_ff[i] <= cmd_code_in != `APCC_WR_PLAIN;
                    mon_ff[i] <= w_mon;
                    pause_ff[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Registered outputs.
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_valid_out <= 1'b0;
            tx_port_out <= 3'h0;
            tx_char_out <= 8'h00;
            rx_store_valid_out <= 1'b0;
            rx_store_port_out <= 3'h0;
            rx_store_char_out <= 8'h00;
            stat_valid_out <= 1'b0;
            stat_port_out <= 3'h0;
            stat_tx_out <= 1'b0;
            stat_code_out <= 8'h00;
            rd_start_out <= 1'b0;
            rd_port_out <= 3'h0;
            rd_type_out <= 2'h0;
            rd_ctl_det_out <= 1'b0;
            rd_spec_det_out <= 1'b0;
            rd_purge_out <= 1'b0;
            rd_dtr_flow_out <= 1'b0;
            wr_active_out <= 8'h00;
            tx_paused_out <= 8'h00;
            monitor_out <= 8'h00;
        end else begin
            // Character held until the line side takes it.
            if (send) begin
                tx_valid_out <= 1'b1;
                tx_port_out <= hp;
                tx_char_out <= fifo_data[7:0];
            end else if (tx_ready_in) begin
                tx_valid_out <= 1'b0;
            end
            // Everything not swallowed goes to the type ahead buffer.
            rx_store_valid_out <= rx_valid_in & ~consume;
            rx_store_port_out <= rx_port_in;
            rx_store_char_out <= rx_char_in;
            // Status: reject first, otherwise the lowest pending completion.
            stat_valid_out <= reject | (served != 8'h00);
            if (reject) begin
                stat_port_out <= cport;
                stat_tx_out <= tx_hit;
                stat_code_out <= `APCC_ST_UNIT_CHECK;
            end else begin
                stat_port_out <= dp;
                stat_tx_out <= 1'b1;
                stat_code_out <= `APCC_ST_CEDE;
            end
            // Read start with decoded modifier flags.
            rd_start_out <= acc_r;
            rd_port_out <= cport;
            rd_type_out <= rtype;
            rd_ctl_det_out <= cmd_code_in[`APCC_RD_CTL_BIT];
            rd_spec_det_out <= cmd_code_in[`APCC_RD_SPEC_BIT];
            rd_purge_out <= cmd_code_in[`APCC_RD_PURGE_BIT];
            rd_dtr_flow_out <= (rtype == `APCC_RT_HW) &
                cmd_code_in[`APCC_RD_SEL_BIT];
            wr_active_out <= act_ff;
            tx_paused_out <= pause_ff & mon_wr_ff;
            monitor_out <= mon_ff;
        end
    end
endmodule

// ---- logic/apcc_map.vh ----
`ifndef APCC_MAP_VH
`define APCC_MAP_VH

// ==========================================================
// Port subaddresses.
`define APCC_SA_RX_BASE 8'he0
`define APCC_SA_TX_BASE 8'he8
`define APCC_SA_PORT_MASK 8'hf8
`define APCC_PORT_ZERO 3'h0

// ==========================================================
// Write command codes.
`define APCC_WR_PLAIN 8'h01
`define APCC_WR_MON 8'h05
`define APCC_WR_HW 8'h0d

// ==========================================================
// Read command fields and low nibble read types.
`define APCC_RD_TYPE_READ 4'h2
`define APCC_RD_TYPE_ECHO 4'h6
`define APCC_RD_TYPE_FLOW 4'ha
`define APCC_RD_TYPE_HW 4'he
`define APCC_RD_SEL_BIT 7
`define APCC_RD_CTL_BIT 6
`define APCC_RD_SPEC_BIT 5
`define APCC_RD_PURGE_BIT 4

// Read type codes driven out on the read start port.
`define APCC_RT_READ 2'h0
`define APCC_RT_ECHO 2'h1
`define APCC_RT_FLOW 2'h2
`define APCC_RT_HW 2'h3

// ==========================================================
// Flow and framing characters.
`define APCC_CH_DC3 8'h13
`define APCC_CH_DC1 8'h11
`define APCC_CH_ETX 8'h03

// ==========================================================
// Status bytes returned to the channel.
`define APCC_ST_CEDE 8'h0c
`define APCC_ST_UNIT_CHECK 8'h0e

// ==========================================================
// Widths and sizes.
`define APCC_PORTS 8
`define APCC_CNT_W 16
`define APCC_CNT_ZERO 16'h0000
`define APCC_CNT_ONE 16'h0001
`define APCC_FIFO_DEPTH 8
`define APCC_FIFO_AW 3
`define APCC_FIFO_W 11

`endif

// ---- tb/apcc_line_model.sv ----
// ====================
// Line side model: takes characters, promptly or with stalls.
module apcc_line_model (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic slow_in,
    input wire logic tx_valid_in,
    input wire logic [2:0] tx_port_in,
    input wire logic [7:0] tx_char_in,
    output logic tx_ready_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [10:0] got [$];
    logic [1:0] ctr_ff;
    // Ready every cycle, or one cycle in four when slow, to hold chars on the line.
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_ready_out <= 1'b0;
            ctr_ff <= 2'h0;
        end else begin
            ctr_ff <= ctr_ff + 2'h1;
            tx_ready_out <= !slow_in || ctr_ff == 2'h3;
            if (tx_valid_in && tx_ready_out) begin
                got.push_back({tx_port_in, tx_char_in});
            end
        end
    end
endmodule

// ---- tb/apcc_cmd_sva.sv ----
// ====================
// Checker on the command block ports.
module apcc_cmd_chk (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_subaddr_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic single_port_jumper_in,
    input wire logic [7:0] dsr_in,
    input wire logic [7:0] full_duplex_in,
    input wire logic [7:0] ring_enable_in,
    input wire logic tx_valid_out,
    input wire logic [2:0] tx_port_out,
    input wire logic [7:0] tx_char_out,
    input wire logic tx_ready_in,
    input wire logic rx_valid_in,
    input wire logic [2:0] rx_port_in,
    input wire logic [7:0] rx_char_in,
    input wire logic rx_store_valid_out,
    input wire logic [2:0] rx_store_port_out,
    input wire logic [7:0] rx_store_char_out,
    input wire logic stat_valid_out,
    input wire logic [2:0] stat_port_out,
    input wire logic stat_tx_out,
    input wire logic [7:0] stat_code_out,
    input wire logic rd_start_out,
    input wire logic [2:0] rd_port_out,
    input wire logic [1:0] rd_type_out,
    input wire logic rd_ctl_det_out,
    input wire logic rd_spec_det_out,
    input wire logic rd_purge_out,
    input wire logic rd_dtr_flow_out,
    input wire logic [7:0] wr_active_out,
    input wire logic [7:0] tx_paused_out,
    input wire logic [7:0] monitor_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    wire [2:0] cp = cmd_subaddr_in[2:0];
    wire sel_ok = !single_port_jumper_in || cp == 3'h0;
    wire rx_sa = cmd_subaddr_in[7:3] == 5'h1c;
    wire tx_sa = cmd_subaddr_in[7:3] == 5'h1d;
    wire dsr_ok = dsr_in[cp] || (full_duplex_in[cp] && ring_enable_in[cp]);
    wire mon_rx = monitor_out[rx_port_in];
    logic [2:0] dc3_port_ff;
    // Remembers the port of the last received character.
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) dc3_port_ff <= 3'h0;
        else if (rx_valid_in) dc3_port_ff <= rx_port_in;
    end
    a_wrong_dir: assert property (cmd_valid_in && rx_sa && sel_ok && cmd_code_in == 8'h01
        |=> stat_valid_out && stat_code_out == 8'h0e && !stat_tx_out && stat_port_out == $past(cp))
        else $error("write code on receive side not refused");
    a_jumper_ignore: assert property (cmd_valid_in && rx_sa && single_port_jumper_in
        && cp != 3'h0 |=> !rd_start_out) else $error("jumper did not hide port");
    a_write_dsr: assert property (cmd_valid_in && tx_sa && sel_ok && !dsr_ok
        |=> stat_valid_out && stat_tx_out && stat_code_out == 8'h0e)
        else $error("write with DSR low not refused");
    a_read_dsr: assert property (cmd_valid_in && rx_sa && !dsr_ok |=> !rd_start_out)
        else $error("read with DSR low accepted");
    a_read_fields: assert property (rd_start_out |-> rd_type_out == $past(cmd_code_in[3:2])
        && rd_port_out == $past(cp) && rd_ctl_det_out == $past(cmd_code_in[6])
        && rd_spec_det_out == $past(cmd_code_in[5]) && rd_purge_out == $past(cmd_code_in[4]))
        else $error("read decode wrong");
    a_read_dtr: assert property (rd_start_out |-> $past(cmd_valid_in && rx_sa)
        && rd_dtr_flow_out == $past(cmd_code_in[7])) else $error("flow line select wrong");
    a_tx_hold: assert property (tx_valid_out && !tx_ready_in
        |=> tx_valid_out && $stable(tx_char_out) && $stable(tx_port_out))
        else $error("line char dropped before taken");
    a_dc3_pause: assert property (rx_valid_in && rx_char_in == 8'h13 && mon_rx
        && wr_active_out[rx_port_in] |-> ##[1:2] tx_paused_out[dc3_port_ff])
        else $error("stop char did not pause");
    a_rx_store: assert property (rx_valid_in && rx_char_in != 8'h03
        && !(mon_rx && (rx_char_in == 8'h13 || rx_char_in == 8'h11))
        |=> rx_store_valid_out && rx_store_char_out == $past(rx_char_in)
        && rx_store_port_out == $past(rx_port_in)) else $error("char not stored");
endmodule

bind apcc_cmd apcc_cmd_chk chk (.sys_clk_in, .rst_b_in, .cmd_valid_in, .cmd_subaddr_in,
    .cmd_code_in, .single_port_jumper_in, .dsr_in, .full_duplex_in, .ring_enable_in,
    .tx_valid_out, .tx_port_out, .tx_char_out, .tx_ready_in, .rx_valid_in, .rx_port_in,
    .rx_char_in, .rx_store_valid_out, .rx_store_port_out, .rx_store_char_out,
    .stat_valid_out, .stat_port_out, .stat_tx_out, .stat_code_out, .rd_start_out,
    .rd_port_out, .rd_type_out, .rd_ctl_det_out, .rd_spec_det_out, .rd_purge_out,
    .rd_dtr_flow_out, .wr_active_out, .tx_paused_out, .monitor_out);

// ---- tb/test_apcc_cmd.sv ----
// ====================
// Bench for the port command block.
module test_apcc_cmd;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_in = 0, rst_b_in = 0, cmd_valid_in = 0, single_port_jumper_in = 0;
    logic [7:0] cmd_subaddr_in = 0, cmd_code_in = 0, dsr_in = 8'hff, cts_in = 8'hff;
    logic [7:0] full_duplex_in = 8'hff, ring_enable_in = 0, port_reinit_in = 0;
    logic [15:0] cmd_count_in = 0, st_cap, rd_cap, sto_cap;
    logic wr_data_valid_in = 0, tx_ready_in, rx_valid_in = 0, slow = 0, ok;
    logic [2:0] wr_data_port_in = 0, rx_port_in = 0;
    logic [7:0] wr_data_in = 0, rx_char_in = 0;
    logic [7:0] codes [5] = '{8'h02, 8'h76, 8'h0a, 8'h8e, 8'h6e};
    wire wr_data_ready_out, tx_valid_out, rx_store_valid_out, stat_valid_out, stat_tx_out;
    wire rd_start_out, rd_ctl_det_out, rd_spec_det_out, rd_purge_out, rd_dtr_flow_out;
    wire [2:0] tx_port_out, rx_store_port_out, stat_port_out, rd_port_out;
    wire [1:0] rd_type_out;
    wire [7:0] tx_char_out, rx_store_char_out, stat_code_out, wr_active_out;
    wire [7:0] tx_paused_out, monitor_out;
    int errors = 0, compares = 0, cyc = 0, n, i, m = 0;
    apcc_cmd dut (.sys_clk_in, .rst_b_in, .cmd_valid_in, .cmd_subaddr_in, .cmd_code_in,
        .cmd_count_in, .single_port_jumper_in, .dsr_in, .cts_in, .full_duplex_in,
        .ring_enable_in, .port_reinit_in, .wr_data_valid_in, .wr_data_port_in, .wr_data_in,
        .wr_data_ready_out, .tx_valid_out, .tx_port_out, .tx_char_out, .tx_ready_in,
        .rx_valid_in, .rx_port_in, .rx_char_in, .rx_store_valid_out, .rx_store_port_out,
        .rx_store_char_out, .stat_valid_out, .stat_port_out, .stat_tx_out, .stat_code_out,
        .rd_start_out, .rd_port_out, .rd_type_out, .rd_ctl_det_out, .rd_spec_det_out,
        .rd_purge_out, .rd_dtr_flow_out, .wr_active_out, .tx_paused_out, .monitor_out);
    apcc_line_model line (.sys_clk_in, .rst_b_in, .slow_in(slow), .tx_valid_in(tx_valid_out),
        .tx_port_in(tx_port_out), .tx_char_in(tx_char_out), .tx_ready_out(tx_ready_in));
    // Clock and hang guard.
    always #4 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results;
        end
    end
    function automatic logic [15:0] stv(input logic tx, input logic [2:0] p, input logic [7:0] c);
        return {3'h0, 1'b1, tx, p, c};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Command pulse; status and read start are caught one cycle later.
    task automatic cmd(input logic [7:0] sa, input logic [7:0] code, input logic [15:0] cnt);
        @(negedge sys_clk_in);
        cmd_valid_in = 1;
        cmd_subaddr_in = sa;
        cmd_code_in = code;
        cmd_count_in = cnt;
        @(negedge sys_clk_in);
        st_cap = {3'h0, stat_valid_out, stat_tx_out, stat_port_out, stat_code_out};
        rd_cap = {6'h00, rd_start_out, rd_type_out, rd_ctl_det_out, rd_spec_det_out,
            rd_purge_out, rd_dtr_flow_out, rd_port_out};
        cmd_valid_in = 0;
    endtask
    task automatic rx(input logic [2:0] p, input logic [7:0] c);
        @(negedge sys_clk_in);
        rx_valid_in = 1;
        rx_port_in = p;
        rx_char_in = c;
        @(negedge sys_clk_in);
        sto_cap = {4'h0, rx_store_valid_out, rx_store_port_out, rx_store_char_out};
        rx_valid_in = 0;
    endtask
    task automatic push(input logic [2:0] p, input logic [7:0] d, input bit wt, output logic k);
        int w;
        @(negedge sys_clk_in);
        wr_data_valid_in = 1;
        wr_data_port_in = p;
        wr_data_in = d;
        w = 0;
        while (wt && wr_data_ready_out !== 1'b1 && w < 300) begin
            @(negedge sys_clk_in);
            w++;
        end
        k = wr_data_ready_out;
        @(negedge sys_clk_in);
        wr_data_valid_in = 0;
    endtask
    task automatic wait_stat(input logic [2:0] p, input logic [7:0] c);
        int w;
        w = 0;
        while (stat_valid_out !== 1'b1 && w < 400) begin
            @(negedge sys_clk_in);
            w++;
        end
        chk({3'h0, stat_valid_out, stat_tx_out, stat_port_out, stat_code_out}, stv(1, p, c));
        @(negedge sys_clk_in);
    endtask
    task automatic results;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (20) @(negedge sys_clk_in);
        rst_b_in = 1;
        cmd(8'he1, 8'h01, 16'h0001); chk(st_cap, stv(0, 1, 8'h0e));
        cmd(8'he9, 8'h02, 16'h0000); chk(st_cap, stv(1, 1, 8'h0e));
        dsr_in = 8'hfb;
        cmd(8'hea, 8'h01, 16'h0001); chk(st_cap, stv(1, 2, 8'h0e));
        cmd(8'he2, 8'h02, 16'h0000); chk(st_cap, stv(0, 2, 8'h0e));
        ring_enable_in = 8'h04;
        cmd(8'he2, 8'h02, 16'h0000); chk(rd_cap, {6'h00, 1'b1, 6'h00, 3'h2});
        cmd(8'hea, 8'h01, 16'h0001);
        push(3'h2, 8'h5a, 1, ok);
        wait_stat(3'h2, 8'h0c);
        dsr_in = 8'hff;
        for (i = 0; i < 5; i++) begin
            cmd(8'he3, codes[i], 16'h0000);
            chk(rd_cap, {6'h00, 1'b1, codes[i][3:2], codes[i][6:4], codes[i][7], 3'h3});
        end
        for (i = 0; i < 8; i++) begin
            cmd(8'he0 | i[7:0], 8'h02, 16'h0000); chk(rd_cap[9:0], {7'h40, i[2:0]});
        end
        slow = 1;
        cmd(8'he9, 8'h01, 16'h0003);
        cmd(8'he9, 8'h01, 16'h0002); chk(st_cap, stv(1, 1, 8'h0e));
        chk(wr_active_out, 8'h02);
        cmd(8'he1, 8'h02, 16'h0000); chk(rd_cap, {6'h00, 1'b1, 6'h00, 3'h1});
        n = line.got.size();
        for (i = 1; i < 4; i++) push(3'h1, 8'ha0 + i[7:0], 1, ok);
        wait_stat(3'h1, 8'h0c);
        // Status follows the load of the last character; the slow line may still hold it.
        repeat (4) @(negedge sys_clk_in);
        for (i = 1; i < 4; i++) chk(line.got[n + i - 1], {3'h1, 8'ha0 + i[7:0]});
        slow = 0;
        cmd(8'he8, 8'h05, 16'h0004);
        rx(3'h0, 8'h13);
        n = line.got.size();
        push(3'h0, 8'hc1, 1, ok);
        push(3'h0, 8'hc2, 1, ok);
        repeat (8) @(negedge sys_clk_in);
        chk(tx_paused_out, 8'h01);
        chk(line.got.size() == n, 1'b1);
        rx(3'h0, 8'h41); chk(sto_cap, {5'h01, 3'h0, 8'h41});
        rx(3'h0, 8'h11);
        repeat (6) @(negedge sys_clk_in);
        chk(line.got.size() == n + 2, 1'b1);
        chk(tx_paused_out, 8'h00);
        rx(3'h0, 8'h03);
        wait_stat(3'h0, 8'h0c);
        chk(monitor_out, 8'h01);
        rx(3'h0, 8'h13); chk(sto_cap[11], 1'b0);
        rx(3'h0, 8'h11);
        cmd(8'he8, 8'h01, 16'h0001);
        push(3'h0, 8'hc3, 1, ok);
        wait_stat(3'h0, 8'h0c);
        chk(monitor_out, 8'h00);
        cts_in = 8'hef;
        cmd(8'hec, 8'h0d, 16'h0009);
        n = line.got.size();
        for (i = 0; i < 10; i++) begin
            push(3'h4, i[7:0], 0, ok);
            if (ok === 1'b1) m++;
        end
        chk(m[15:0], 16'h0008);
        chk(line.got.size() == n, 1'b1);
        cmd(8'he4, 8'h02, 16'h0000); chk(rd_cap[9], 1'b1);
        cts_in = 8'hff;
        push(3'h4, 8'h08, 1, ok);
        wait_stat(3'h4, 8'h0c);
        chk(line.got[n + 8], {3'h4, 8'h08});
        single_port_jumper_in = 1;
        cmd(8'he1, 8'h02, 16'h0000); chk({st_cap[12], rd_cap[9]}, 2'h0);
        cmd(8'he9, 8'h01, 16'h0001); chk(st_cap[12], 1'b0);
        cmd(8'he0, 8'h02, 16'h0000); chk(rd_cap[9], 1'b1);
        single_port_jumper_in = 0;
        results;
    end
endmodule
